// ===== rtl/bififo_pkg.sv
// Shared constants for the two-way queue pair, its device end and its host end.
// Assumes both ends run on one clock and meet through bififo_if.
// Operation
// - Port drives bus only when selected and reading
// - Port A write stores word in A-to-B queue
// - Port A read loads next B-to-A word
// - Port B decodes like A; writes B-to-A queue
// - Port B read loads next A-to-B word
// - Port A mail read frees B-to-A mail flag
// - Port B mail read frees A-to-B mail flag
// - Selects change only while enable is low
// - Queue flag releases pass two register stages
// - Reads while empty flag low are ignored
// - Read pointer steps per word loaded out
// - Empty flag rises two edges after write
// - Write edge itself never counts as sync
// - Writes while full flag low are ignored
// - Write pointer steps per accepted word
// - Full flag rises two edges after read
// - Read edge itself never counts as sync
// - Empty and almost-empty follow word count
// - Almost-full and full follow word count
// - Mail write while flag high stores word, drops flag low
// - Bus shows mail or queue output register
// - Offset loaded from selects at reset release
// - Reset clears pointers and presets flags
package bififo_pkg;
  localparam int WORD_W = 36;
  localparam int DEPTH_LOG2 = 6;
  localparam int OFFSET_W = 5;
  localparam logic [4:0] OFFSET_SEL_HH = 5'h10;
  localparam logic [4:0] OFFSET_SEL_HL = 5'h0c;
  localparam logic [4:0] OFFSET_SEL_LH = 5'h08;
  localparam logic [4:0] OFFSET_SEL_LL = 5'h04;
  localparam logic [4:0] OFFSET_RESET = 5'h04;
  // Flag vector positions, all flags active low
  localparam int FLAG_EMPTY = 0;
  localparam int FLAG_ALMOST_EMPTY = 1;
  localparam int FLAG_ALMOST_FULL = 2;
  localparam int FLAG_FULL = 3;
  localparam logic [3:0] FLAGS_RESET = 4'h4;
  localparam logic MAIL_FLAG_RESET = 1'b1;
  // Skew between a transfer edge and the first edge that may count for it
  localparam int CLOCK_PERIOD_NS = 50;
  localparam int MIN_SYNC_SKEW_NS = 8;
  localparam int MIN_SYNC_SKEW_CYC =
    ((MIN_SYNC_SKEW_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS > 0) ?
    (MIN_SYNC_SKEW_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS : 1;
  // Host register map, byte offsets
  localparam logic [4:0] REG_COMMAND = 5'h00;
  localparam logic [4:0] REG_WDATA_LO = 5'h04;
  localparam logic [4:0] REG_WDATA_HI = 5'h08;
  localparam logic [4:0] REG_RDATA_LO = 5'h0c;
  localparam logic [4:0] REG_RDATA_HI = 5'h10;
  localparam logic [4:0] REG_STATUS = 5'h14;
  localparam logic [4:0] REG_CONFIG = 5'h18;
  localparam int CMD_PORT_BIT = 0;
  localparam int CMD_MAIL_BIT = 1;
  localparam int CMD_WRITE_BIT = 2;
  localparam logic WAITREQ_RESET = 1'b1;
endpackage

// ===== rtl/bififo_if.sv
// Pins between the queue device and its host; resolves both data buses.
// Assumes each end drives its own copy of a bus and an active-low enable.
`timescale 1ns/1ps
interface bififo_if;
  logic        porta_select_n;
  logic        porta_write_not_read;
  logic        porta_enable;
  logic        porta_mailbox_select;
  logic [35:0] porta_host_data;
  logic        porta_host_oe_n;
  logic [35:0] porta_dev_data;
  logic        porta_dev_oe_n;
  logic [35:0] porta_data_bus;
  logic        porta_full_n;
  logic        porta_almost_full_n;
  logic        porta_empty_n;
  logic        porta_almost_empty_n;
  logic        portb_select_n;
  logic        portb_write_not_read;
  logic        portb_enable;
  logic        portb_mailbox_select;
  logic [35:0] portb_host_data;
  logic        portb_host_oe_n;
  logic [35:0] portb_dev_data;
  logic        portb_dev_oe_n;
  logic [35:0] portb_data_bus;
  logic        portb_full_n;
  logic        portb_almost_full_n;
  logic        portb_empty_n;
  logic        portb_almost_empty_n;
  logic        a_to_b_mail_flag_n;
  logic        b_to_a_mail_flag_n;
  logic        offset_select_lo;
  logic        offset_select_hi;

  // Device wins while it drives; an undriven bus shows no stale word
  assign porta_data_bus = !porta_dev_oe_n  ? porta_dev_data  :
                          !porta_host_oe_n ? porta_host_data : ~porta_host_data;
  assign portb_data_bus = !portb_dev_oe_n  ? portb_dev_data  :
                          !portb_host_oe_n ? portb_host_data : ~portb_host_data;

  modport device (
    input  porta_select_n, porta_write_not_read, porta_enable, porta_mailbox_select,
    input  portb_select_n, portb_write_not_read, portb_enable, portb_mailbox_select,
    input  porta_data_bus, portb_data_bus, offset_select_lo, offset_select_hi,
    output porta_dev_data, porta_dev_oe_n, portb_dev_data, portb_dev_oe_n,
    output porta_full_n, porta_almost_full_n, porta_empty_n, porta_almost_empty_n,
    output portb_full_n, portb_almost_full_n, portb_empty_n, portb_almost_empty_n,
    output a_to_b_mail_flag_n, b_to_a_mail_flag_n
  );
  modport host (
    output porta_select_n, porta_write_not_read, porta_enable, porta_mailbox_select,
    output portb_select_n, portb_write_not_read, portb_enable, portb_mailbox_select,
    output porta_host_data, porta_host_oe_n, portb_host_data, portb_host_oe_n,
    output offset_select_lo, offset_select_hi,
    input  porta_data_bus, portb_data_bus,
    input  porta_full_n, porta_almost_full_n, porta_empty_n, porta_almost_empty_n,
    input  portb_full_n, portb_almost_full_n, portb_empty_n, portb_almost_empty_n,
    input  a_to_b_mail_flag_n, b_to_a_mail_flag_n
  );
endinterface

// ===== rtl/queue_core.sv
// One direction of the pair: storage, pointers, word count and four flags.
// Assumes the caller has decoded the port controls into wr_req and rd_req.
`timescale 1ns/1ps
module queue_core
  import bififo_pkg::*;
#(
  parameter int WIDTH      = 36,
  parameter int DEPTH_LOG2 = 6
) (
  input  wire logic                clock,
  input  wire logic                clock_enable,
  input  wire logic                sys_rst,
  input  wire logic                wr_req,
  input  wire logic [WIDTH-1:0]    wr_data,
  input  wire logic                rd_req,
  input  wire logic [OFFSET_W-1:0] offset,
  output logic      [WIDTH-1:0]    head_word,
  output logic                     rd_fire,
  output logic                     full_n,
  output logic                     almost_full_n,
  output logic                     empty_n,
  output logic                     almost_empty_n
);
  localparam int DEPTH = 1 << DEPTH_LOG2;
  typedef logic [DEPTH_LOG2:0] count_t;
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [DEPTH_LOG2-1:0]       wr_ptr;
    logic [DEPTH_LOG2-1:0]       rd_ptr;
    count_t                      count;
    logic [3:0]                  stage1;
    logic [3:0]                  stage2;
  } core_state_t;

  core_state_t st_r;
  core_state_t st_nxt;
  logic        wr_fire;

  // Level of each flag for a given count, before synchronisation
  function automatic logic [3:0] raw_flags(input count_t c, input logic [OFFSET_W-1:0] x);
    logic [3:0] f;
    f = 4'h0;
    f[FLAG_EMPTY]        = (c != count_t'(0));
    f[FLAG_ALMOST_EMPTY] = (c > count_t'(x));
    f[FLAG_ALMOST_FULL]  = (c < count_t'(DEPTH) - count_t'(x));
    f[FLAG_FULL]         = (c != count_t'(DEPTH));
    return f;
  endfunction

  // Transfers qualified by the synchronised flags
  assign wr_fire   = wr_req && st_r.stage2[FLAG_FULL];
  assign rd_fire   = rd_req && st_r.stage2[FLAG_EMPTY];
  assign head_word = st_r.mem[st_r.rd_ptr];

  // Next state of the whole direction
  always_comb
  begin
    st_nxt = st_r;
    if (wr_fire)
    begin
      st_nxt.mem[st_r.wr_ptr] = wr_data;
      st_nxt.wr_ptr = st_r.wr_ptr + 1'b1;
    end
    if (rd_fire)
    begin
      st_nxt.rd_ptr = st_r.rd_ptr + 1'b1;
    end
    st_nxt.count = count_t'(st_r.count + count_t'(wr_fire) - count_t'(rd_fire));
    // Stage one sees the old count, so the transfer edge never counts
    st_nxt.stage1 = raw_flags(st_r.count, offset);
    // Releases wait two edges; warnings fall at once to stop overrun
    st_nxt.stage2 = st_r.stage1 & raw_flags(st_nxt.count, offset);
    if (sys_rst)
    begin
      st_nxt.wr_ptr = '0;
      st_nxt.rd_ptr = '0;
      st_nxt.count  = '0;
      st_nxt.stage1 = FLAGS_RESET;
      st_nxt.stage2 = FLAGS_RESET;
    end
  end

  // Single state register, frozen while the clock enable is low
  always_ff @(posedge clock)
  begin
    if (clock_enable)
      st_r <= st_nxt;
  end

  assign empty_n        = st_r.stage2[FLAG_EMPTY];
  assign almost_empty_n = st_r.stage2[FLAG_ALMOST_EMPTY];
  assign almost_full_n  = st_r.stage2[FLAG_ALMOST_FULL];
  assign full_n         = st_r.stage2[FLAG_FULL];
endmodule // queue_core

// ===== rtl/bififo_device.sv
// Device end: port decode, mail registers, output registers, two queues.
// Assumes the host keeps selects still around edges that enable a transfer.
`timescale 1ns/1ps
module bififo_device
  import bififo_pkg::*;
#(
  parameter int WIDTH      = 36,
  parameter int DEPTH_LOG2 = 6
) (
  input  wire logic clock,
  input  wire logic clock_enable,
  input  wire logic sys_rst,
  bififo_if.device  itf
);
  typedef struct packed {
    logic [OFFSET_W-1:0] offset;
    logic                load_pending;
    logic [WIDTH-1:0]    mail_ab;
    logic [WIDTH-1:0]    mail_ba;
    logic                mail_ab_flag_n;
    logic                mail_ba_flag_n;
    logic [WIDTH-1:0]    outreg_a;
    logic [WIDTH-1:0]    outreg_b;
    logic [WIDTH-1:0]    data_a;
    logic [WIDTH-1:0]    data_b;
    logic                oe_a_n;
    logic                oe_b_n;
  } dev_state_t;

  dev_state_t       st_r;
  dev_state_t       st_nxt;
  logic             a_go;
  logic             a_fifo_wr;
  logic             a_fifo_rd;
  logic             a_mail_wr;
  logic             a_mail_rd;
  logic             b_go;
  logic             b_fifo_wr;
  logic             b_fifo_rd;
  logic             b_mail_wr;
  logic             b_mail_rd;
  logic [WIDTH-1:0] ab_head;
  logic [WIDTH-1:0] ba_head;
  logic             ab_rd_fire;
  logic             ba_rd_fire;

  // Port A decode; enable low means no queue or mail transfer, though bus drive still follows select
  assign a_go      = !itf.porta_select_n && itf.porta_enable;
  assign a_fifo_wr = a_go && itf.porta_write_not_read && !itf.porta_mailbox_select;
  assign a_fifo_rd = a_go && !itf.porta_write_not_read && !itf.porta_mailbox_select;
  assign a_mail_wr = a_go && itf.porta_write_not_read && itf.porta_mailbox_select;
  assign a_mail_rd = a_go && !itf.porta_write_not_read && itf.porta_mailbox_select;

  // Port B decode, same table as port A
  assign b_go      = !itf.portb_select_n && itf.portb_enable;
  assign b_fifo_wr = b_go && itf.portb_write_not_read && !itf.portb_mailbox_select;
  assign b_fifo_rd = b_go && !itf.portb_write_not_read && !itf.portb_mailbox_select;
  assign b_mail_wr = b_go && itf.portb_write_not_read && itf.portb_mailbox_select;
  assign b_mail_rd = b_go && !itf.portb_write_not_read && itf.portb_mailbox_select;

  // Queue written by port A, drained by port B
  queue_core #(
    .WIDTH      (WIDTH),
    .DEPTH_LOG2 (DEPTH_LOG2)
  ) u_a_to_b_queue (
    .clock          (clock),
    .clock_enable   (clock_enable),
    .sys_rst        (sys_rst),
    .wr_req         (a_fifo_wr),
    .wr_data        (itf.porta_data_bus),
    .rd_req         (b_fifo_rd),
    .offset         (st_r.offset),
    .head_word      (ab_head),
    .rd_fire        (ab_rd_fire),
    .full_n         (itf.porta_full_n),
    .almost_full_n  (itf.porta_almost_full_n),
    .empty_n        (itf.portb_empty_n),
    .almost_empty_n (itf.portb_almost_empty_n)
  );

  // Queue written by port B, drained by port A
  queue_core #(
    .WIDTH      (WIDTH),
    .DEPTH_LOG2 (DEPTH_LOG2)
  ) u_b_to_a_queue (
    .clock          (clock),
    .clock_enable   (clock_enable),
    .sys_rst        (sys_rst),
    .wr_req         (b_fifo_wr),
    .wr_data        (itf.portb_data_bus),
    .rd_req         (a_fifo_rd),
    .offset         (st_r.offset),
    .head_word      (ba_head),
    .rd_fire        (ba_rd_fire),
    .full_n         (itf.portb_full_n),
    .almost_full_n  (itf.portb_almost_full_n),
    .empty_n        (itf.porta_empty_n),
    .almost_empty_n (itf.porta_almost_empty_n)
  );

  // Next state: offset load, mail, output registers, bus drive
  always_comb
  begin
    st_nxt = st_r;
    // Strap taken on the first enabled edge after reset drops
    if (st_r.load_pending)
    begin
      st_nxt.load_pending = 1'b0;
      case ({itf.offset_select_hi, itf.offset_select_lo})
        2'b11:   st_nxt.offset = OFFSET_SEL_HH;
        2'b10:   st_nxt.offset = OFFSET_SEL_HL;
        2'b01:   st_nxt.offset = OFFSET_SEL_LH;
        default: st_nxt.offset = OFFSET_SEL_LL;
      endcase
    end
    // Mail reads free the flag; a write placed after so it would win
    if (b_mail_rd)
      st_nxt.mail_ab_flag_n = 1'b1;
    if (a_mail_rd)
      st_nxt.mail_ba_flag_n = 1'b1;
    if (a_mail_wr && st_r.mail_ab_flag_n)
    begin
      st_nxt.mail_ab        = itf.porta_data_bus;
      st_nxt.mail_ab_flag_n = 1'b0;
    end
    if (b_mail_wr && st_r.mail_ba_flag_n)
    begin
      st_nxt.mail_ba        = itf.portb_data_bus;
      st_nxt.mail_ba_flag_n = 1'b0;
    end
    // Output registers load only on an accepted queue read
    if (ba_rd_fire)
      st_nxt.outreg_a = ba_head;
    if (ab_rd_fire)
      st_nxt.outreg_b = ab_head;
    // Bus source follows mailbox select; registered, so one cycle late
    st_nxt.data_a = itf.porta_mailbox_select ? st_nxt.mail_ba : st_nxt.outreg_a;
    st_nxt.data_b = itf.portb_mailbox_select ? st_nxt.mail_ab : st_nxt.outreg_b;
    st_nxt.oe_a_n = itf.porta_select_n || itf.porta_write_not_read;
    st_nxt.oe_b_n = itf.portb_select_n || itf.portb_write_not_read;
    if (sys_rst)
    begin
      st_nxt                = '0;
      st_nxt.offset         = OFFSET_RESET;
      st_nxt.load_pending   = 1'b1;
      st_nxt.mail_ab_flag_n = MAIL_FLAG_RESET;
      st_nxt.mail_ba_flag_n = MAIL_FLAG_RESET;
      st_nxt.oe_a_n         = 1'b1;
      st_nxt.oe_b_n         = 1'b1;
    end
  end

  // Single state register, frozen while the clock enable is low
  always_ff @(posedge clock)
  begin
    if (clock_enable)
      st_r <= st_nxt;
  end

  // Outputs straight from the state register
  assign itf.porta_dev_data     = st_r.data_a;
  assign itf.porta_dev_oe_n     = st_r.oe_a_n;
  assign itf.portb_dev_data     = st_r.data_b;
  assign itf.portb_dev_oe_n     = st_r.oe_b_n;
  assign itf.a_to_b_mail_flag_n = st_r.mail_ab_flag_n;
  assign itf.b_to_a_mail_flag_n = st_r.mail_ba_flag_n;
endmodule // bififo_device

// ===== rtl/bififo_host.sv
// Host end: Avalon-MM slave registers turned into single port cycles.
// Assumes one Avalon master that holds its request until waitrequest is low.
//
// The placing of the registers and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
module bififo_host
  import bififo_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        clock_enable,
  input  wire logic        sys_rst,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  bififo_if.host           itf
);
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_SETUP  = 3'h1,
    ST_STROBE = 3'h3,
    ST_HOLD   = 3'h2,
    ST_ACK    = 3'h6
  } host_state_t;

  typedef struct packed {
    host_state_t      state;
    logic             cmd_port;
    logic             cmd_write;
    logic [35:0]      wdata;
    logic [35:0]      rdata;
    logic [31:0]      readdata;
    logic             waitrequest;
    logic [1:0]       offset_sel;
    logic [1:0]       sel_n;
    logic [1:0]       wnr;
    logic [1:0]       en;
    logic [1:0]       mb;
    logic [1:0]       oe_n;
  } host_st_t;

  host_st_t    st_r;
  host_st_t    st_nxt;
  logic [31:0] read_mux;
  logic        idx;

  // Register read decode; unmapped offsets read as zero
  always_comb
  begin
    read_mux = 32'h0;
    if (avs_address == REG_WDATA_LO)
      read_mux = st_r.wdata[31:0];
    else if (avs_address == REG_WDATA_HI)
      read_mux = {28'h0, st_r.wdata[35:32]};
    else if (avs_address == REG_RDATA_LO)
      read_mux = st_r.rdata[31:0];
    else if (avs_address == REG_RDATA_HI)
      read_mux = {28'h0, st_r.rdata[35:32]};
    else if (avs_address == REG_STATUS)
      read_mux = {22'h0, itf.b_to_a_mail_flag_n, itf.a_to_b_mail_flag_n,
                  itf.portb_full_n, itf.portb_almost_full_n,
                  itf.portb_almost_empty_n, itf.portb_empty_n,
                  itf.porta_full_n, itf.porta_almost_full_n,
                  itf.porta_almost_empty_n, itf.porta_empty_n};
    else if (avs_address == REG_CONFIG)
      read_mux = {30'h0, st_r.offset_sel};
  end

  // Port cycle: selects set, enable pulse, enable drop, release
  always_comb
  begin
    st_nxt = st_r;
    idx    = avs_writedata[CMD_PORT_BIT];
    case (st_r.state)
      ST_IDLE:
        if (avs_write && avs_address == REG_COMMAND)
        begin
          st_nxt.cmd_port   = idx;
          st_nxt.cmd_write  = avs_writedata[CMD_WRITE_BIT];
          st_nxt.sel_n[idx] = 1'b0;
          st_nxt.wnr[idx]   = avs_writedata[CMD_WRITE_BIT];
          st_nxt.mb[idx]    = avs_writedata[CMD_MAIL_BIT];
          st_nxt.oe_n[idx]  = !avs_writedata[CMD_WRITE_BIT];
          st_nxt.state      = ST_SETUP;
        end
        else if (avs_write)
          st_nxt.state = ST_ACK;
        else if (avs_read)
        begin
          st_nxt.readdata = read_mux;
          st_nxt.state    = ST_ACK;
        end
      ST_SETUP:
      begin
        st_nxt.en[st_r.cmd_port] = 1'b1;
        st_nxt.state             = ST_STROBE;
      end
      ST_STROBE:
      begin
        st_nxt.en    = 2'b00;
        st_nxt.state = ST_HOLD;
      end
      ST_HOLD:
      begin
        if (!st_r.cmd_write)
          st_nxt.rdata = st_r.cmd_port ? itf.portb_data_bus : itf.porta_data_bus;
        st_nxt.sel_n = 2'b11;
        st_nxt.wnr   = 2'b00;
        st_nxt.mb    = 2'b00;
        st_nxt.oe_n  = 2'b11;
        st_nxt.state = ST_ACK;
      end
      default:
      begin
        // Register writes land on the accepting edge only
        if (avs_write && avs_address == REG_WDATA_LO)
          st_nxt.wdata[31:0] = avs_writedata;
        else if (avs_write && avs_address == REG_WDATA_HI)
          st_nxt.wdata[35:32] = avs_writedata[3:0];
        else if (avs_write && avs_address == REG_CONFIG)
          st_nxt.offset_sel = avs_writedata[1:0];
        st_nxt.state = ST_IDLE;
      end
    endcase
    st_nxt.waitrequest = (st_nxt.state != ST_ACK);
    if (sys_rst)
    begin
      st_nxt             = '0;
      st_nxt.state       = ST_IDLE;
      st_nxt.waitrequest = WAITREQ_RESET;
      st_nxt.sel_n       = 2'b11;
      st_nxt.oe_n        = 2'b11;
    end
  end

  // Single state register, frozen while the clock enable is low
  always_ff @(posedge clock)
  begin
    if (clock_enable)
      st_r <= st_nxt;
  end

  // Pins and bus answer straight from the state register
  assign avs_readdata             = st_r.readdata;
  assign avs_waitrequest          = st_r.waitrequest;
  assign itf.porta_select_n       = st_r.sel_n[0];
  assign itf.porta_write_not_read = st_r.wnr[0];
  assign itf.porta_enable         = st_r.en[0];
  assign itf.porta_mailbox_select = st_r.mb[0];
  assign itf.porta_host_data      = st_r.wdata;
  assign itf.porta_host_oe_n      = st_r.oe_n[0];
  assign itf.portb_select_n       = st_r.sel_n[1];
  assign itf.portb_write_not_read = st_r.wnr[1];
  assign itf.portb_enable         = st_r.en[1];
  assign itf.portb_mailbox_select = st_r.mb[1];
  assign itf.portb_host_data      = st_r.wdata;
  assign itf.portb_host_oe_n      = st_r.oe_n[1];
  assign itf.offset_select_lo     = st_r.offset_sel[0];
  assign itf.offset_select_hi     = st_r.offset_sel[1];
endmodule // bififo_host

// ===== dv/bififo_checker.sv
// Timing checks on the pins that join the device end and the host end.
// Assumes one clock; sys_rst is the device reset, so a host-only reset is not seen.
`timescale 1ns/1ps
module bififo_checker (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic porta_select_n,
  input wire logic porta_write_not_read,
  input wire logic porta_enable,
  input wire logic porta_mailbox_select,
  input wire logic portb_select_n,
  input wire logic portb_write_not_read,
  input wire logic portb_enable,
  input wire logic portb_mailbox_select,
  input wire logic porta_dev_oe_n,
  input wire logic portb_dev_oe_n,
  input wire logic porta_full_n,
  input wire logic portb_empty_n,
  input wire logic portb_almost_empty_n,
  input wire logic a_to_b_mail_flag_n,
  input wire logic b_to_a_mail_flag_n
);
  logic a_on, b_on, a_wr, b_rd, a_mw, a_mr, b_mr;

  // Port cycles decoded from the host controls
  assign a_on = !porta_select_n && !porta_write_not_read;
  assign b_on = !portb_select_n && !portb_write_not_read;
  assign a_wr = !porta_select_n && porta_write_not_read && porta_enable && !porta_mailbox_select;
  assign b_rd = b_on && portb_enable && !portb_mailbox_select;
  assign a_mw = !porta_select_n && porta_write_not_read && porta_enable && porta_mailbox_select;
  assign a_mr = a_on && porta_enable && porta_mailbox_select;
  assign b_mr = b_on && portb_enable && portb_mailbox_select;

  // Whole checker lives in one domain
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  a_drive_porta: assert property (porta_dev_oe_n == !$past(a_on))
    else $error("port a drive enable wrong");
  a_drive_portb: assert property (portb_dev_oe_n == !$past(b_on))
    else $error("port b drive enable wrong");
  a_full_cause: assert property ($fell(porta_full_n) |-> $past(a_wr))
    else $error("full flag fell without a write");
  a_empty_cause: assert property ($fell(portb_empty_n) |-> $past(b_rd))
    else $error("empty flag fell without a read");
  a_empty_sync: assert property ($rose(portb_empty_n) |-> $past(a_wr, 3))
    else $error("empty flag rose off the second edge");
  a_full_boot: assert property ($fell(sys_rst) |-> !porta_full_n ##[1:3] porta_full_n)
    else $error("full flag late after reset");
  a_mail_set: assert property (a_mw && a_to_b_mail_flag_n |=> !a_to_b_mail_flag_n)
    else $error("mail flag not set by mail write");
  a_mail_free_b: assert property (b_mr |=> a_to_b_mail_flag_n)
    else $error("port b mail read kept flag low");
  a_mail_free_a: assert property (a_mr |=> b_to_a_mail_flag_n)
    else $error("port a mail read kept flag low");
  a_aempty_order: assert property (!portb_empty_n |-> !portb_almost_empty_n)
    else $error("almost empty high while empty");
  a_sel_steady: assert property (porta_enable |-> $stable(porta_select_n))
    else $error("port a select moved while enabled");

  // Refused writes, refused reads and ignored mail writes are reached
  c_full_write: cover property (a_wr && !porta_full_n);
  c_empty_read: cover property (b_rd && !portb_empty_n);
  c_mail_block: cover property (a_mw && !a_to_b_mail_flag_n);
endmodule // bififo_checker

// ===== dv/bidirectional_dual_clock_fifo_test.sv
// Bench: Avalon master on the host end, device end behind the pins, results via a queue.
// Assumes one 20 MHz clock; the device has its own reset so a new offset can load.
`timescale 1ns/1ps
module bidirectional_dual_clock_fifo_test;
  import bififo_pkg::*;
  logic        clock = 1'b0;
  logic        host_rst = 1'b1;
  logic        dev_rst = 1'b1;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [31:0] seed = 32'h8620;
  logic [31:0] exp_q[$];
  logic [35:0] words[$];
  logic [1:0]  mail_n = 2'b11;
  int          cnt[2];
  int          x_off = 4;
  int          err_count = 0;
  int          n_checks = 0;

  bififo_if itf ();
  bififo_device i_bififo_device (.clock(clock), .clock_enable(1'b1), .sys_rst(dev_rst),
    .itf(itf.device));
  bififo_host i_bififo_host (.clock(clock), .clock_enable(1'b1), .sys_rst(host_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .itf(itf.host));
  bififo_checker i_bififo_checker (.clock(clock), .sys_rst(dev_rst),
    .porta_select_n(itf.porta_select_n), .porta_write_not_read(itf.porta_write_not_read),
    .porta_enable(itf.porta_enable), .porta_mailbox_select(itf.porta_mailbox_select),
    .portb_select_n(itf.portb_select_n), .portb_write_not_read(itf.portb_write_not_read),
    .portb_enable(itf.portb_enable), .portb_mailbox_select(itf.portb_mailbox_select),
    .porta_dev_oe_n(itf.porta_dev_oe_n), .portb_dev_oe_n(itf.portb_dev_oe_n),
    .porta_full_n(itf.porta_full_n), .portb_empty_n(itf.portb_empty_n),
    .portb_almost_empty_n(itf.portb_almost_empty_n),
    .a_to_b_mail_flag_n(itf.a_to_b_mail_flag_n), .b_to_a_mail_flag_n(itf.b_to_a_mail_flag_n));

  always #25 clock = ~clock;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Flag nibble from read-side and write-side word counts
  function automatic logic [3:0] nib(int rc, int wc);
    return {wc != 64, wc < 64 - x_off, rc > x_off, rc != 0};
  endfunction

  task automatic stop_test();
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
    if (g !== e) err_count++;
  endtask

  // Results are compared where they appear, oldest note first
  always @(posedge clock)
    if (avs_read && avs_waitrequest === 1'b0) cmp(exp_q.pop_front(), avs_readdata);

  // One Avalon transfer; request held until waitrequest is seen low
  task automatic bus(input logic [4:0] a, input logic rd, input logic [31:0] d);
    int i;
    avs_address <= a;
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= d;
    for (i = 0; i < 50; i++)
    begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 50) err_count++;
    if (i == 50) stop_test();
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b1, 32'h0);
  endtask

  task automatic st();
    rd(REG_STATUS, {22'h0, mail_n, nib(cnt[0], cnt[1]), nib(cnt[1], cnt[0])});
  endtask

  // Port command, then room for the two-edge flag sync
  task automatic cmd(input logic [2:0] c);
    bus(REG_COMMAND, 1'b0, {29'h0, c});
    repeat (3) @(posedge clock);
  endtask

  task automatic put(input logic p, input logic mb, input logic [35:0] w);
    bus(REG_WDATA_LO, 1'b0, w[31:0]);
    bus(REG_WDATA_HI, 1'b0, {28'h0, w[35:32]});
    cmd({1'b1, mb, p});
  endtask

  task automatic get(input logic p, input logic mb, input logic [35:0] e);
    cmd({1'b0, mb, p});
    rd(REG_RDATA_LO, e[31:0]);
    rd(REG_RDATA_HI, {28'h0, e[35:32]});
  endtask

  // Fill past full from port p, then drain past empty from the other port
  task automatic flow(input logic p);
    logic [35:0] w;
    logic [35:0] last;
    for (int i = 0; i < 65; i++)
    begin
      w = {4'(rnd()), rnd()};
      put(p, 1'b0, w);
      if (cnt[p] < 64) words.push_back(w);
      if (cnt[p] < 64) cnt[p]++;
      st();
    end
    for (int i = 0; i < 65; i++)
    begin
      if (cnt[p] > 0) last = words.pop_front();
      if (cnt[p] > 0) cnt[p]--;
      get(!p, 1'b0, last);
      st();
    end
  endtask

  // Second mail write is refused while the first is unread
  task automatic mail(input logic p);
    logic [35:0] w;
    w = {4'(rnd()), rnd()};
    put(p, 1'b1, w);
    mail_n[p] = 1'b0;
    put(p, 1'b1, ~w);
    st();
    get(!p, 1'b1, w);
    mail_n[p] = 1'b1;
    st();
  endtask

  initial
  begin
    repeat (20) @(posedge clock);
    host_rst <= 1'b0;
    dev_rst <= 1'b0;
    @(posedge clock);
    rd(5'h1c, 32'h0);
    rd(REG_COMMAND, 32'h0);
    // Each offset choice loads at device reset release; odd ones run B to A
    for (int c = 0; c < 4; c++)
    begin
      bus(REG_CONFIG, 1'b0, 32'(c));
      dev_rst <= 1'b1;
      repeat (20) @(posedge clock);
      dev_rst <= 1'b0;
      repeat (3) @(posedge clock);
      x_off = 4 + 4 * c;
      cnt = '{0, 0};
      st();
      flow(c[0]);
      mail(c[0]);
    end
    stop_test();
  end
endmodule // bidirectional_dual_clock_fifo_test
